//--- rtl/sidm_map.svh
// constants for the serial identity bus master
`ifndef SIDM_MAP_SVH
`define SIDM_MAP_SVH

`define SIDM_CLK_MHZ      125
`define SIDM_CMD_READ     8'h33
`define SIDM_CMD_SEARCH   8'hF0
`define SIDM_CMD_MATCH    8'h55
`define SIDM_CMD_SKIP     8'hCC
`define SIDM_CRC_POLY     8'h8C
`define SIDM_ID_BITS      64
// times in microseconds
`define SIDM_T_RSTL_US    480
`define SIDM_T_RSTH_US    480
`define SIDM_T_MSP_US     70
`define SIDM_T_SLOT_US    70
`define SIDM_T_W0L_US     60
`define SIDM_T_W1L_US     6
`define SIDM_T_RL_US      6
`define SIDM_T_MSR_US     13
`define SIDM_T_REC_US     5
`define SIDM_T_RESET_US   120
// shortest data slot that keeps the bit rate within its limit
`define SIDM_T_SLOTMIN_US 61

`endif

//--- rtl/sidm_pkg.sv
// types for the serial identity bus master
package sidm_pkg;
    typedef enum logic [8:0] {
        SIDM_IDLE  = 9'h001,
        SIDM_RSTL  = 9'h002,
        SIDM_RSTH  = 9'h004,
        SIDM_CMD   = 9'h008,
        SIDM_RDID  = 9'h010,
        SIDM_SRTR  = 9'h020,
        SIDM_SRCP  = 9'h040,
        SIDM_SRWR  = 9'h080,
        SIDM_DONE  = 9'h100
    } sidm_state_t;

    typedef enum logic [1:0] {
        SIDM_SL_W0 = 2'h0,
        SIDM_SL_W1 = 2'h1,
        SIDM_SL_RD = 2'h2
    } sidm_slot_t;
endpackage

//--- rtl/sidm_slot.sv
// one timed bus slot: reset/presence, write or read
`timescale 1ns/1ps
`include "sidm_map.svh"
module sidm_slot
    import sidm_pkg::*;
#(
    parameter int CLK_MHZ  = `SIDM_CLK_MHZ,
    parameter int RSTL_CYC = `SIDM_T_RSTL_US * CLK_MHZ,
    parameter int RSTH_CYC = `SIDM_T_RSTH_US * CLK_MHZ,
    parameter int SLOT_CYC = `SIDM_T_SLOT_US * CLK_MHZ
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic       go_reset,
    input  wire sidm_slot_t kind,
    input  wire logic       line_s,
    output logic            busy,
    output logic            done,
    output logic            bit_in,
    output logic            line_oe
);
    localparam int W0L_CYC     = `SIDM_T_W0L_US * CLK_MHZ;
    localparam int W1L_CYC     = `SIDM_T_W1L_US * CLK_MHZ;
    localparam int MSR_CYC     = `SIDM_T_MSR_US * CLK_MHZ;
    localparam int MSP_CYC     = `SIDM_T_MSP_US * CLK_MHZ;
    localparam int REC_CYC     = `SIDM_T_REC_US * CLK_MHZ;
    localparam int RST_LIM     = `SIDM_T_RESET_US * CLK_MHZ;
    localparam int SLOTMIN_CYC = `SIDM_T_SLOTMIN_US * CLK_MHZ;

    typedef struct packed {
        logic       act;
        logic       rsq;
        sidm_slot_t kind;
        logic [19:0] cnt;
        logic       oe;
        logic       smp;
        logic       dn;
    } sidm_slot_reg_t;

    sidm_slot_reg_t s;
    sidm_slot_reg_t next_s;
    logic [19:0]    low_end;
    logic [19:0]    smp_at;
    logic [19:0]    tot;

    // phase boundaries depend on the slot kind
    always_comb begin
        low_end = s.rsq ? 20'(RSTL_CYC) :
                  (s.kind == SIDM_SL_W0) ? 20'(W0L_CYC) : 20'(W1L_CYC);
        smp_at  = s.rsq ? 20'(RSTL_CYC + MSP_CYC) : 20'(MSR_CYC);
        tot     = s.rsq ? 20'(RSTL_CYC + RSTH_CYC) :
                  20'((s.kind == SIDM_SL_W0 ? W0L_CYC : SLOT_CYC) + REC_CYC);
    end

    // slot sequencer; line is only pulled, never driven high
    always_comb begin
        next_s    = s;
        next_s.dn = 1'b0;
        if (!s.act) begin
            if (go || go_reset) begin
                next_s.act  = 1'b1;
                next_s.rsq  = go_reset;
                next_s.kind = kind;
                next_s.cnt  = 20'h00000;
                next_s.oe   = 1'b1;
            end
        end else begin
            next_s.cnt = s.cnt + 20'h00001;
            if (s.cnt + 20'h00001 == low_end) begin
                next_s.oe = 1'b0;
            end
            if (s.cnt + 20'h00001 == smp_at) begin
                next_s.smp = line_s;
            end
            if (s.cnt + 20'h00001 == tot) begin
                next_s.act = 1'b0;
                next_s.dn  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '{act: 1'b0, rsq: 1'b0, kind: SIDM_SL_W1, cnt: 20'h00000,
                   oe: 1'b0, smp: 1'b0, dn: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign busy    = s.act;
    assign done    = s.dn;
    assign bit_in  = s.smp;
    assign line_oe = s.oe;

    // a data slot never holds the line low long enough to reset slaves
    oe_short_a: assert property (@(posedge clk) disable iff (rst)
        (s.act && !s.rsq && s.oe) |-> (s.cnt < 20'(RST_LIM)))
        else $error("data slot low too long");
    reset_low_a: assert property (@(posedge clk) disable iff (rst)
        (s.act && s.rsq && s.cnt < 20'(RSTL_CYC - 1)) |-> s.oe)
        else $error("reset pulse released early");
    slot_start_a: assert property (@(posedge clk) disable iff (rst)
        $rose(s.act) |-> s.oe)
        else $error("slot did not start low");
    // a shorter slot would push the bit rate past its limit
    slot_rate_a: assert property (@(posedge clk) disable iff (rst)
        (s.act && !s.rsq && (s.cnt + 20'h00001 == tot)) |-> (tot >= 20'(SLOTMIN_CYC)))
        else $error("data slot too short");
endmodule

//--- rtl/sidm_master.sv
// bus master: reset, read identity and search passes with crc check
`timescale 1ns/1ps
`include "sidm_map.svh"
module sidm_master
    import sidm_pkg::*;
#(
    parameter int CLK_MHZ  = `SIDM_CLK_MHZ,
    parameter int RSTL_CYC = `SIDM_T_RSTL_US * CLK_MHZ,
    parameter int RSTH_CYC = `SIDM_T_RSTH_US * CLK_MHZ,
    parameter int SLOT_CYC = `SIDM_T_SLOT_US * CLK_MHZ
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start_read,
    input  wire logic        start_search,
    input  wire logic [63:0] search_dir,
    input  wire logic        line_in,
    output logic             line_out,
    output logic             line_oe,
    output logic             busy,
    output logic             done,
    output logic             present,
    output logic             crc_ok,
    output logic             search_fail,
    output logic [63:0]      id,
    output logic [63:0]      branch_map
);
    typedef struct packed {
        sidm_state_t st;
        logic        srch;
        logic [5:0]  idx;
        logic [2:0]  cbit;
        logic [7:0]  crc;
        logic [63:0] id;
        logic [63:0] brm;
        logic        tbit;
        logic        pres;
        logic        ok;
        logic        fail;
        logic        dn;
        logic        s1;
        logic        s2;
    } sidm_reg_t;

    sidm_reg_t  r;
    sidm_reg_t  next_r;
    logic       go;
    logic       go_reset;
    sidm_slot_t kind;
    logic       sl_busy;
    logic       sl_done;
    logic       sl_bit;
    logic [7:0] cmd;
    logic       wbit;

    // crc step, lsb-first feed, reflected polynomial
    function automatic logic [7:0] sidm_crc(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        sidm_crc = (c >> 1) ^ (fb ? `SIDM_CRC_POLY : 8'h00);
    endfunction

    sidm_slot #(
        .CLK_MHZ  (CLK_MHZ),
        .RSTL_CYC (RSTL_CYC),
        .RSTH_CYC (RSTH_CYC),
        .SLOT_CYC (SLOT_CYC)
    ) u_slot (
        .clk      (clk),
        .rst      (rst),
        .go       (go),
        .go_reset (go_reset),
        .kind     (kind),
        .line_s   (r.s2),
        .busy     (sl_busy),
        .done     (sl_done),
        .bit_in   (sl_bit),
        .line_oe  (line_oe)
    );

    // command byte and chosen search bit
    assign cmd  = r.srch ? `SIDM_CMD_SEARCH : `SIDM_CMD_READ;
    always_comb begin
        if (!r.tbit && !sl_bit) begin
            wbit = search_dir[r.idx];
        end else begin
            wbit = r.tbit;
        end
    end

    // slot requests issued by the sequencer
    always_comb begin
        go       = 1'b0;
        go_reset = 1'b0;
        kind     = SIDM_SL_RD;
        if (!sl_busy && !sl_done) begin
            case (r.st)
                SIDM_RSTL: begin
                    go_reset = 1'b1;
                end
                SIDM_CMD: begin
                    go   = 1'b1;
                    kind = cmd[r.cbit] ? SIDM_SL_W1 : SIDM_SL_W0;
                end
                SIDM_RDID, SIDM_SRTR, SIDM_SRCP: begin
                    go = 1'b1;
                end
                SIDM_SRWR: begin
                    go   = 1'b1;
                    kind = r.id[r.idx] ? SIDM_SL_W1 : SIDM_SL_W0;
                end
                default: begin
                    go = 1'b0;
                end
            endcase
        end
    end

    // transaction sequencer
    always_comb begin
        next_r    = r;
        next_r.dn = 1'b0;
        next_r.s1 = line_in;
        next_r.s2 = r.s1;
        case (r.st)
            SIDM_IDLE: begin
                if (start_read || start_search) begin
                    next_r.st   = SIDM_RSTL;
                    next_r.srch = start_search && !start_read; // read needs a lone slave
                    next_r.crc  = 8'h00;
                    next_r.idx  = 6'h00;
                    next_r.cbit = 3'h0;
                    next_r.brm  = 64'h0000000000000000;
                    next_r.fail = 1'b0;
                    next_r.ok   = 1'b0;
                    next_r.pres = 1'b0;
                end
            end
            SIDM_RSTL: begin
                if (sl_done) begin
                    next_r.pres = !sl_bit;
                    next_r.st   = sl_bit ? SIDM_DONE : SIDM_CMD;
                end
            end
            SIDM_CMD: begin
                if (sl_done) begin
                    next_r.cbit = r.cbit + 3'h1;
                    if (r.cbit == 3'h7) begin
                        next_r.st = r.srch ? SIDM_SRTR : SIDM_RDID;
                    end
                end
            end
            SIDM_RDID: begin
                if (sl_done) begin
                    next_r.id[r.idx] = sl_bit;
                    next_r.crc       = sidm_crc(r.crc, sl_bit);
                    next_r.idx       = r.idx + 6'h01;
                    if (r.idx == 6'h3F) begin
                        next_r.st = SIDM_DONE;
                    end
                end
            end
            SIDM_SRTR: begin
                if (sl_done) begin
                    next_r.tbit = sl_bit;
                    next_r.st   = SIDM_SRCP;
                end
            end
            SIDM_SRCP: begin
                if (sl_done) begin
                    if (r.tbit && sl_bit) begin
                        next_r.fail = 1'b1; // no participant left
                        next_r.st   = SIDM_DONE;
                    end else begin
                        next_r.brm[r.idx] = !r.tbit && !sl_bit;
                        next_r.id[r.idx]  = wbit;
                        next_r.st         = SIDM_SRWR;
                    end
                end
            end
            SIDM_SRWR: begin
                if (sl_done) begin
                    next_r.crc = sidm_crc(r.crc, r.id[r.idx]);
                    next_r.idx = r.idx + 6'h01;
                    next_r.st  = (r.idx == 6'h3F) ? SIDM_DONE : SIDM_SRTR;
                end
            end
            SIDM_DONE: begin
                next_r.ok = r.pres && !r.fail && (r.crc == 8'h00);
                next_r.dn = 1'b1;
                next_r.st = SIDM_IDLE;
            end
            default: begin
                next_r.st = SIDM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{st: SIDM_IDLE, srch: 1'b0, idx: 6'h00, cbit: 3'h0, crc: 8'h00,
                   id: 64'h0000000000000000, brm: 64'h0000000000000000,
                   tbit: 1'b0, pres: 1'b0, ok: 1'b0, fail: 1'b0, dn: 1'b0,
                   s1: 1'b1, s2: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    // open drain: the driven level is always low
    assign line_out    = 1'b0;
    assign busy        = (r.st != SIDM_IDLE);
    assign done        = r.dn;
    assign present     = r.pres;
    assign crc_ok      = r.ok;
    assign search_fail = r.fail;
    assign id          = r.id;
    assign branch_map  = r.brm;

    cmd_after_pres_a: assert property (@(posedge clk) disable iff (rst)
        (r.st == SIDM_RSTL && next_r.st == SIDM_CMD) |-> !sl_bit)
        else $error("command without presence");
    idle_release_a: assert property (@(posedge clk) disable iff (rst)
        (r.st == SIDM_IDLE) |-> !line_oe)
        else $error("line held while idle");
    crc_reset_a: assert property (@(posedge clk) disable iff (rst)
        (r.st == SIDM_RSTL) |-> (r.crc == 8'h00))
        else $error("crc not cleared");
    done_pulse_a: assert property (@(posedge clk) disable iff (rst)
        done |=> !done)
        else $error("done longer than one cycle");
    ok_rule_a: assert property (@(posedge clk) disable iff (rst)
        (done && crc_ok) |-> (present && !search_fail))
        else $error("crc ok without presence");
endmodule

//--- verification/sidm_dev_model.sv
// behavioural identity slave on the open-drain line
`timescale 1ns/1ps
module sidm_dev_model #(
    parameter logic [63:0] ROM   = 64'h0,
    parameter real         US_NS = 1000.0 // ns per microsecond of bus time
) (
    input  wire logic bus,
    input  wire logic attached,
    output logic      pull_low
);
    realtime    t_fall;
    int         mode;
    int         cnt;
    int         ph;
    logic [7:0] cmd;
    logic       pres;
    logic       b;

    initial begin
        pull_low = 1'b0;
        mode     = 0;
        pres     = 1'b0;
        t_fall   = 0.0;
    end

    // long low seen at the rising edge: restart, then answer presence
    always @(posedge bus) begin
        if (attached && $realtime - t_fall > 120.0 * US_NS) begin
            mode = 1;
            cnt  = 0;
            ph   = 0;
            pres = 1'b1;
            #(20.0 * US_NS) pull_low = 1'b1;
            #(100.0 * US_NS) pull_low = 1'b0;
            pres = 1'b0;
        end
    end

    // slots timed from the master's fall; mode 0 silent, 1 command, 2 read, 3 search
    always @(negedge bus) begin
        t_fall = $realtime;
        if (attached && !pres && mode != 0) begin
            if (mode == 1 || (mode == 3 && ph == 2)) begin
                #(30.0 * US_NS) b = bus;
                if (mode == 1) begin
                    cmd = {b, cmd[7:1]};
                    cnt++;
                    if (cnt == 8) begin
                        mode = (cmd == 8'h33) ? 2 : (cmd == 8'hF0) ? 3 : 0;
                        cnt  = 0;
                    end
                end else begin
                    mode = (b == ROM[cnt] && cnt < 63) ? 3 : 0;
                    ph   = 0;
                    cnt++;
                end
            end else begin
                b = (mode == 2 || ph == 0) ? ROM[cnt] : ~ROM[cnt];
                ph++;
                if (mode == 2) begin
                    cnt++;
                    mode = (cnt == 64) ? 0 : 2;
                end
                // hold a zero well past the master's sample point
                pull_low = ~b;
                #(30.0 * US_NS) pull_low = 1'b0;
            end
        end
    end
endmodule

//--- verification/sidm_master_tb.sv
// self-checking bench for the serial identity bus master
`timescale 1ns/1ps
module sidm_master_tb;
    import sidm_pkg::*;
    logic        clk;
    logic        rst;
    logic        start_read;
    logic        start_search;
    logic [63:0] search_dir;
    logic        line_out;
    logic        line_oe;
    logic        busy;
    logic        done;
    logic        present;
    logic        crc_ok;
    logic        search_fail;
    logic [63:0] id;
    logic [63:0] branch_map;
    logic        att_a;
    logic        att_b;
    logic        pull_a;
    logic        pull_b;
    wire         bus;
    int          error_cnt;
    int          cmp_count;

    // crc over the n lowest identity bits, lsb first
    function automatic logic [7:0] crc_of(input logic [63:0] v, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            c = (c[0] ^ v[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
        end
        return c;
    endfunction

    // family and serial values are arbitrary; families first differ at bit 3
    localparam logic [55:0] BASE_A = 56'h00004D2C1B3E5A;
    localparam logic [55:0] BASE_B = 56'h00004D2C1B3E72;
    localparam logic [63:0] ROM_A  = {crc_of({8'h00, BASE_A}, 56), BASE_A};
    localparam logic [63:0] ROM_B  = {crc_of({8'h00, BASE_B}, 56), BASE_B};
    localparam logic [63:0] BR     = 64'h8;
    // the design counts each clock as one microsecond so a search fits the run budget
    localparam real         US     = 8.0;

    sidm_master #(.CLK_MHZ(1)) dut (
        .clk          (clk),
        .rst          (rst),
        .start_read   (start_read),
        .start_search (start_search),
        .search_dir   (search_dir),
        .line_in      (bus),
        .line_out     (line_out),
        .line_oe      (line_oe),
        .busy         (busy),
        .done         (done),
        .present      (present),
        .crc_ok       (crc_ok),
        .search_fail  (search_fail),
        .id           (id),
        .branch_map   (branch_map)
    );
    sidm_dev_model #(.ROM(ROM_A), .US_NS(US)) dev_a (
        .bus      (bus),
        .attached (att_a),
        .pull_low (pull_a)
    );
    sidm_dev_model #(.ROM(ROM_B), .US_NS(US)) dev_b (
        .bus      (bus),
        .attached (att_b),
        .pull_low (pull_b)
    );

    // pull-up wire: any low wins
    assign bus = (line_oe ? line_out : 1'b1) & ~pull_a & ~pull_b;

    always #4 clk = ~clk;

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one transaction; an opposite start while busy must be ignored
    task automatic run(input logic rd, input logic [63:0] dir);
        int n;
        start_read   <= rd;
        start_search <= ~rd;
        search_dir   <= dir;
        @(posedge clk);
        start_read   <= 1'b0;
        start_search <= 1'b0;
        repeat (4) @(posedge clk);
        chk("busy", 64'h1, {63'h0, busy});
        start_read   <= ~rd;
        start_search <= rd;
        @(posedge clk);
        start_read   <= 1'b0;
        start_search <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 30000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 30000) begin
            error_cnt++;
            $display("MISMATCH done expected 1 seen timeout");
            results();
        end
        chk("bus idle", 64'h1, {63'h0, bus});
        chk("line_out", 64'h0, {63'h0, line_out});
    endtask

    task automatic t_none;
        att_a <= 1'b0;
        att_b <= 1'b0;
        run(1'b1, 64'h0);
        chk("present", 64'h0, {63'h0, present});
        chk("crc_ok", 64'h0, {63'h0, crc_ok});
        $display("test none finished");
    endtask

    task automatic t_read;
        att_a <= 1'b1;
        run(1'b1, 64'h0);
        chk("id", ROM_A, id);
        chk("present", 64'h1, {63'h0, present});
        chk("crc_ok", 64'h1, {63'h0, crc_ok});
        $display("test read finished");
    endtask

    // both answer at once: crc_ok must match the crc of the wired-and result
    task automatic t_collide;
        att_b <= 1'b1;
        run(1'b1, 64'h0);
        chk("id", ROM_A & ROM_B, id);
        chk("crc_ok", {63'h0, crc_of(ROM_A & ROM_B, 64) == 8'h00}, {63'h0, crc_ok});
        $display("test collide finished");
    endtask

    task automatic t_search;
        run(1'b0, 64'h0);
        chk("id", ROM_B, id);
        chk("branch_map", BR, branch_map);
        chk("search_fail", 64'h0, {63'h0, search_fail});
        chk("crc_ok", 64'h1, {63'h0, crc_ok});
        $display("test search finished");
    endtask

    // reset in mid-search, then the other branch finds the other device
    task automatic t_abort;
        start_search <= 1'b1;
        @(posedge clk);
        start_search <= 1'b0;
        repeat (3000) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("line_oe", 64'h0, {63'h0, line_oe});
        chk("busy", 64'h0, {63'h0, busy});
        chk("id", 64'h0, id);
        rst <= 1'b0;
        @(posedge clk);
        run(1'b0, {64{1'b1}});
        chk("id", ROM_A, id);
        chk("branch_map", BR, branch_map);
        $display("test abort finished");
    endtask

    // the last device vanishes in mid-search: both reads high must fail the pass
    task automatic t_lost;
        int n;
        att_b        <= 1'b0;
        start_search <= 1'b1;
        @(posedge clk);
        start_search <= 1'b0;
        repeat (3000) @(posedge clk);
        att_a <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 30000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 30000) begin
            error_cnt++;
            $display("MISMATCH done expected 1 seen timeout");
            results();
        end
        chk("search_fail", 64'h1, {63'h0, search_fail});
        chk("present", 64'h1, {63'h0, present});
        chk("crc_ok", 64'h0, {63'h0, crc_ok});
        $display("test lost finished");
    endtask

    initial begin
        clk          = 1'b0;
        rst          = 1'b1;
        start_read   = 1'b0;
        start_search = 1'b0;
        search_dir   = 64'h0;
        att_a        = 1'b0;
        att_b        = 1'b0;
        error_cnt    = 0;
        cmp_count    = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_none();
        t_read();
        t_collide();
        t_search();
        t_abort();
        t_lost();
        results();
    end
endmodule
